// *** hw/bcsl_map.vh ***
// Purpose: Constants for the contact stack logic unit
// Assumes: Included by bcsl_core.v
// Notes:   Opcode, combine and area encodings
`ifndef BCSL_MAP_VH
`define BCSL_MAP_VH

// ---------------------------------------------
// Operation codes
// ---------------------------------------------
`define BCSL_OP_NOP         4'h0
`define BCSL_OP_CONTACT     4'h1
`define BCSL_OP_CONTACT_INV 4'h2
`define BCSL_OP_DIRECT      4'h3
`define BCSL_OP_DIRECT_INV  4'h4
`define BCSL_OP_NOT         4'h5
`define BCSL_OP_RISE        4'h6
`define BCSL_OP_FALL        4'h7

// ---------------------------------------------
// Combine modes
// ---------------------------------------------
`define BCSL_CMB_LOAD 2'h0
`define BCSL_CMB_AND  2'h1
`define BCSL_CMB_OR   2'h2

// ---------------------------------------------
// Operand memory areas
// ---------------------------------------------
`define BCSL_AREA_INPUT   3'h0
`define BCSL_AREA_OUTPUT  3'h1
`define BCSL_AREA_MARKER  3'h2
`define BCSL_AREA_SPECIAL 3'h3
`define BCSL_AREA_TIMER   3'h4
`define BCSL_AREA_COUNTER 3'h5
`define BCSL_AREA_VAR     3'h6
`define BCSL_AREA_SEQ     3'h7

`define BCSL_TOS_RESET  1'h0
`define BCSL_DONE_RESET 1'h0
`define BCSL_PIN_RESET  1'h0
`define BCSL_EDGE_RESET 1'h0

`endif

// *** hw/bcsl_core.v ***
// Purpose: Bit-logic contact evaluation against a one-bit stack top
// Assumes: Sequencer issues one instruction per exec strobe; pins are asynchronous
// Notes:   Result appears on tos_q one cycle after exec
`timescale 1ns/1ps
`default_nettype none
`include "bcsl_map.vh"

module bcsl_core #(
  parameter IN_W   = 64,
  parameter IDX_W  = 6,
  parameter EDGE_N = 16,
  parameter EID_W  = 4
) (
  input  wire             mclk,
  input  wire             rstn,
  input  wire             clk_en,
  input  wire [IN_W-1:0]  in_pins,
  input  wire             scan_start,
  input  wire             exec,
  input  wire [3:0]       opcode,
  input  wire [1:0]       combine,
  input  wire [2:0]       area,
  input  wire [IDX_W-1:0] bit_index,
  input  wire             mem_bit,
  input  wire [EID_W-1:0] edge_id,
  output reg              tos_q,
  output reg              done_q,
  output reg  [IN_W-1:0]  image_q
);

  // ---------------------------------------------
  // Pin synchroniser
  // ---------------------------------------------
  // Stage two is the only reader of stage one
  wire [IN_W-1:0]   pin_sync;

  genvar gp;
  generate
    for (gp = 0; gp < IN_W; gp = gp + 1) begin : g_pin
      reg s1_q;
      reg s2_q;

      always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          s1_q <= `BCSL_PIN_RESET;
          s2_q <= `BCSL_PIN_RESET;
        end else if (clk_en) begin
          s1_q <= in_pins[gp];
          s2_q <= s1_q;
        end
      end

      assign pin_sync[gp] = s2_q;
    end
  endgenerate

  // ---------------------------------------------
  // Instruction decode
  // ---------------------------------------------
  // Standard contacts, open or closed
  function is_contact_f;
    input [3:0] op;
    begin
      is_contact_f = (op == `BCSL_OP_CONTACT) || (op == `BCSL_OP_CONTACT_INV);
    end
  endfunction

  // Immediate contacts reading the pins
  function is_direct_f;
    input [3:0] op;
    begin
      is_direct_f = (op == `BCSL_OP_DIRECT) || (op == `BCSL_OP_DIRECT_INV);
    end
  endfunction

  // Closed forms taking the complement
  function is_inverted_f;
    input [3:0] op;
    begin
      is_inverted_f = (op == `BCSL_OP_CONTACT_INV) || (op == `BCSL_OP_DIRECT_INV);
    end
  endfunction

  // Edge detectors
  function is_edge_f;
    input [3:0] op;
    begin
      is_edge_f = (op == `BCSL_OP_RISE) || (op == `BCSL_OP_FALL);
    end
  endfunction

  // ---------------------------------------------
  // Combine with the stack top
  // ---------------------------------------------
  function comb_f;
    input [1:0] mode;
    input       top;
    input       val;
    begin
      case (mode)
        `BCSL_CMB_LOAD: comb_f = val;
        `BCSL_CMB_AND:  comb_f = top & val;
        `BCSL_CMB_OR:   comb_f = top | val;
        default:        comb_f = val;
      endcase
    end
  endfunction

  // ---------------------------------------------
  // Edge detector memories
  // ---------------------------------------------
  // One flop per instance, holding the stack top it last saw
  wire              edge_wr;
  wire [EDGE_N-1:0] edge_sel;
  wire [EDGE_N-1:0] edge_prev;

  assign edge_wr  = exec & is_edge_f(opcode);
  assign edge_sel = {{(EDGE_N-1){1'b0}}, 1'b1} << edge_id;

  genvar ge;
  generate
    for (ge = 0; ge < EDGE_N; ge = ge + 1) begin : g_edge
      reg last_q;

      always @(posedge mclk or negedge rstn) begin
        if (!rstn)
          last_q <= `BCSL_EDGE_RESET;
        else if (clk_en && edge_wr && edge_sel[ge])
          last_q <= tos_q;
      end

      assign edge_prev[ge] = last_q;
    end
  endgenerate

  // ---------------------------------------------
  // Operand selection
  // ---------------------------------------------
  reg               opnd_img;
  reg               opnd_raw;
  reg               opnd_val;

  always @* begin
    // Input area reads the image; other areas arrive as mem_bit
    if (area == `BCSL_AREA_INPUT)
      opnd_img = image_q[bit_index];
    else
      opnd_img = mem_bit;
    if (is_direct_f(opcode))
      opnd_raw = pin_sync[bit_index];
    else
      opnd_raw = opnd_img;
    if (is_inverted_f(opcode))
      opnd_val = ~opnd_raw;
    else
      opnd_val = opnd_raw;
  end

  // ---------------------------------------------
  // Stack top next value
  // ---------------------------------------------
  reg               tos_d;
  reg               prev_bit;

  // Edge ops compare against this instance's stored top
  always @* begin
    prev_bit = edge_prev[edge_id];
    tos_d    = tos_q;
    if (exec) begin
      if (is_contact_f(opcode) || is_direct_f(opcode))
        tos_d = comb_f(combine, tos_q, opnd_val);
      else begin
        case (opcode)
          `BCSL_OP_NOT:  tos_d = ~tos_q;
          `BCSL_OP_RISE: tos_d = tos_q & ~prev_bit;
          `BCSL_OP_FALL: tos_d = ~tos_q & prev_bit;
          default:       tos_d = tos_q;
        endcase
      end
    end
  end

  // ---------------------------------------------
  // Image and done next values
  // ---------------------------------------------
  reg               done_d;
  reg [IN_W-1:0]    image_d;

  always @* begin
    // Exec in the scan start cycle still sees the old image
    done_d = exec;
    if (scan_start)
      image_d = pin_sync;
    else
      image_d = image_q;
  end

  // ---------------------------------------------
  // State update
  // ---------------------------------------------
  // Low enable freezes every register, synchroniser included
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tos_q   <= `BCSL_TOS_RESET;
      done_q  <= `BCSL_DONE_RESET;
      image_q <= {IN_W{`BCSL_PIN_RESET}};
    end else if (clk_en) begin
      tos_q   <= tos_d;
      done_q  <= done_d;
      image_q <= image_d;
    end
  end

endmodule
`default_nettype wire

// *** test/bcsl_props.sv ***
// Purpose: core checks; Assumes: default widths; Notes: answer one cycle after exec
`timescale 1ns/1ps
`default_nettype none
module bcsl_props (input wire logic mclk, rstn, clk_en, exec, scan_start, mem_bit, tos_q,
  input wire logic [3:0] opcode, input wire logic [1:0] combine, input wire logic [2:0] area,
  input wire logic [5:0] bit_index, input wire logic [63:0] image_q);
  wire logic [15:0] k = {15'h0000, exec & clk_en} << opcode;
  wire logic b = area ? mem_bit : image_q[bit_index];
  wire logic p = combine == 2'h1 ? tos_q & b : combine == 2'h2 ? tos_q | b : b;
  wire logic q = combine == 2'h1 ? tos_q & ~b : combine == 2'h2 ? tos_q | ~b : ~b;
  wire logic s = k[1] && !combine;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_open_form: assert property (k[1] |=> tos_q == $past(p)) else $error("open");
  a_closed_form: assert property (k[2] |=> tos_q == $past(q)) else $error("closed");
  a_image_read: assert property (s && !area |=> tos_q == $past(b)) else $error("image");
  a_area_read: assert property (s && area |=> tos_q == $past(mem_bit)) else $error("area");
  a_image_kept: assert property ((k[3] || k[4]) && !scan_start |=> $stable(image_q)) else $error("kept");
  a_not_flip: assert property (k[5] |=> tos_q != $past(tos_q)) else $error("not");
  a_rise_gate: assert property (k[6] && !tos_q |=> !tos_q) else $error("rise");
  a_fall_gate: assert property (k[7] && tos_q |=> !tos_q) else $error("fall");
  cover property (k[6] ##1 tos_q);
  cover property (k[7] ##1 tos_q);
  cover property (k[3]);
endmodule
bind bcsl_core bcsl_props u_bcsl_props (.mclk, .rstn, .clk_en, .exec, .scan_start, .mem_bit, .tos_q, .opcode,
  .combine, .area, .bit_index, .image_q);
`default_nettype wire

// *** test/bcsl_mem.sv ***
// Purpose: operand memory model; Assumes: instant fetch; Notes: content is address parity
`timescale 1ns/1ps
`default_nettype none
module bcsl_mem (input wire logic [2:0] area, input wire logic [5:0] bit_index, output logic mem_bit);
  assign mem_bit = ^{area, bit_index};
endmodule
`default_nettype wire

// *** test/tb.sv ***
// Purpose: core bench; Assumes: default widths; Notes: exec every other cycle
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk = 0, rstn = 0, clk_en = 1, scan_start = 0, exec = 0, mem_bit, tos_q, done_q;
  logic [63:0] in_pins = 64'h0000_0000_0000_00f0, image_q;
  logic [3:0] opcode = 0, edge_id = 0;
  logic [1:0] combine = 0;
  logic [2:0] area = 0;
  logic [5:0] bit_index = 0;
  int err_count = 0, checks = 0, cyc = 0;
  always #2 mclk = ~mclk;
  bcsl_core u_bcsl_core (.mclk, .rstn, .clk_en, .in_pins, .scan_start, .exec, .opcode, .combine, .area,
    .bit_index, .mem_bit, .edge_id, .tos_q, .done_q, .image_q);
  bcsl_mem u_bcsl_mem (.area, .bit_index, .mem_bit);
  task print_verdict;
    $display("err_count=%0d checks=%0d", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task ex(input [3:0] o, input [1:0] c, input [2:0] a, input [5:0] i, input e);
    {opcode, combine, area, bit_index, exec} <= {o, c, a, i, 1'b1};
    @(posedge mclk) #1 exec <= 0;
    checks++;
    if ({done_q, tos_q} !== {clk_en, e}) begin
      err_count++;
      $display("unexpected result at %0t: %h %h", $time, {done_q, tos_q}, {clk_en, e});
    end
    @(posedge mclk) #1;
  endtask
  task chk_image(input [63:0] v);
    checks++;
    if (image_q !== v) begin
      err_count++;
      $display("unexpected image at %0t: %h %h", $time, image_q, v);
    end
  endtask
  task t_contacts;
    ex(1, 0, 0, 4, 1);
    ex(1, 1, 0, 0, 0);
    ex(1, 2, 0, 5, 1);
    ex(2, 0, 0, 0, 1);
    ex(2, 1, 0, 4, 0);
    ex(2, 2, 0, 0, 1);
  endtask
  task t_direct;
    in_pins <= 0;
    repeat (3) @(posedge mclk);
    #1 ex(3, 0, 0, 4, 0);
    ex(4, 0, 0, 4, 1);
    ex(1, 0, 0, 4, 1);
    chk_image(64'h0000_0000_0000_00f0);
    scan_start <= 1;
    @(posedge mclk) #1 scan_start <= 0;
    ex(1, 0, 0, 4, 0);
    chk_image(64'h0000_0000_0000_0000);
  endtask
  task t_areas;
    for (int a = 1; a < 8; a++) ex(1, 0, a[2:0], 1, ~^a[2:0]);
  endtask
  task t_edges;
    ex(6, 0, 0, 0, 0);
    ex(1, 0, 1, 0, 1);
    ex(5, 0, 0, 0, 0);
    ex(5, 0, 0, 0, 1);
    ex(6, 0, 0, 0, 1);
    ex(6, 0, 0, 0, 0);
    edge_id <= 1;
    ex(1, 0, 1, 0, 1);
    ex(6, 0, 0, 0, 1);
    edge_id <= 2;
    ex(7, 0, 0, 0, 0);
    ex(1, 0, 0, 0, 0);
    ex(7, 0, 0, 0, 1);
  endtask
  task t_freeze;
    clk_en <= 0;
    ex(5, 0, 0, 0, 1);
    clk_en <= 1;
    ex(5, 0, 0, 0, 0);
  endtask
  always @(posedge mclk) if (++cyc == 500) begin
    err_count++;
    print_verdict;
  end
  initial begin
    repeat (4) @(posedge mclk);
    #1 rstn <= 1;
    repeat (3) @(posedge mclk);
    #1 scan_start <= 1;
    @(posedge mclk) #1 scan_start <= 0;
    chk_image(64'h0000_0000_0000_00f0);
    t_contacts;
    t_direct;
    t_areas;
    t_edges;
    t_freeze;
    print_verdict;
  end
endmodule
`default_nettype wire
